//--- hw/sgoc_top.sv
`timescale 1ns/1ns
module sgoc_top
  import sgoc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
)(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  di_pin,
  input  wire logic [5:0]  rem_open_pin,
  input  wire logic [5:0]  rem_close_pin,
  input  wire logic [5:0]  loc_open_pin,
  input  wire logic [5:0]  loc_close_pin,
  input  wire logic [7:0]  virt_out,
  input  wire logic [7:0]  ext_inhibit,
  input  wire logic [5:0]  ar_open,
  input  wire logic [5:0]  ar_close,
  output logic [5:0]       open_cmd,
  output logic [5:0]       close_cmd,
  output logic [7:0]       obj_fail,
  output logic [N_DO-1:0]  ctrl_out,
  output logic             irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [31:0]      pin_s1;
  logic [31:0]      pin_s2;
  logic [31:0]      pin_s3;
  logic [TICK_W-1:0] tick_cnt;
  logic             tick;
  logic             ctrl_local;
  logic [7:0]       vin;
  logic [STS_W-1:0] sts;
  logic [STS_W-1:0] mask;
  logic [31:0]      omap;
  sgoc_cfg_t        cfg [N_OBJ];
  logic [31:0]      tmr [N_OBJ];
  logic [N_INH-1:0] inh [N_OBJ];
  sgoc_cmd_t        cmd_q;
  logic             cmd_v;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             aw_got;
  logic             w_got;
  logic             wr_do;
  logic [31:0]      rd_mux;
  logic             rd_ok;
  logic [7:0]       undef_evt;
  logic [5:0]       done_evt;
  logic [1:0]       pos [N_OBJ];
  logic [15:0]      cnt [N_OBJ];
  logic [N_INH-1:0] inh_vec;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  function automatic logic src_val(input sgoc_src_t s, input logic [7:0] di,
                                   input logic [7:0] vi, input logic [7:0] vo);
    logic v;
    unique case (s.kind)
      SRC_NONE: v = 1'b0;
      SRC_DI:   v = di[s.idx];
      SRC_VI:   v = vi[s.idx];
      SRC_VO:   v = vo[s.idx];
    endcase
    return v;
  endfunction

  // Setting range enforced here so a zero or huge write cannot disable supervision
  function automatic logic [15:0] clamp(input logic [15:0] t);
    return (t < TICKS_MIN) ? TICKS_MIN : ((t > TICKS_MAX) ? TICKS_MAX : t);
  endfunction

  function automatic logic in_blk(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'(N_OBJ * 4));
  endfunction

  // Pins cross into aclk through two flops; third stage only for edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= 32'h0;
      pin_s2 <= 32'h0;
      pin_s3 <= 32'h0;
    end
    else
    begin
      pin_s1 <= {loc_close_pin, loc_open_pin, rem_close_pin, rem_open_pin, di_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // 10 ms tick enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else
    begin
      tick     <= (tick_cnt == TICK_W'(TICK_CYC - 1));
      tick_cnt <= (tick_cnt == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
    end
  end

  // Own command outputs are deliberately absent from the inhibit vector
  assign inh_vec = {ext_inhibit, vin, pin_s2[7:0]};

  // AXI write path: address and data taken in any order
  assign wr_do = aw_got && w_got && !s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got        <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got        <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr < A_END && aw_addr[1:0] == 2'h0 && aw_addr != 8'h1c)
                        ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_got        <= 1'b0;
        w_got         <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_local <= 1'b0;
      vin        <= 8'h0;
      mask       <= '0;
      omap       <= 32'h0;
      for (int i = 0; i < N_OBJ; i++)
      begin
        cfg[i] <= '0;
        tmr[i] <= TMR_RST;
        inh[i] <= '0;
      end
    end
    else if (wr_do && aw_addr[1:0] == 2'h0) // Unaligned writes answer SLVERR and must not land
    begin
      if (aw_addr == A_CTRL && w_strb[0])
        ctrl_local <= w_data[0];
      if (aw_addr == A_VIN && w_strb[0])
        vin <= w_data[7:0];
      if (aw_addr == A_MASK)
        mask <= STS_W'(merge(32'(mask), w_data, w_strb));
      if (aw_addr == A_OMAP)
        omap <= merge(omap, w_data, w_strb);
      if (in_blk(aw_addr, A_CFG))
        cfg[aw_addr[4:2]] <= sgoc_cfg_t'(merge(cfg[aw_addr[4:2]], w_data, w_strb));
      if (in_blk(aw_addr, A_TMR))
        tmr[aw_addr[4:2]] <= merge(tmr[aw_addr[4:2]], w_data, w_strb);
      if (in_blk(aw_addr, A_INH))
        inh[aw_addr[4:2]] <= N_INH'(merge(32'(inh[aw_addr[4:2]]), w_data, w_strb));
    end
  end

  // Command register write becomes a one-cycle request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_v <= 1'b0;
      cmd_q <= '0;
    end
    else
    begin
      cmd_v <= wr_do && aw_addr == A_CMD;
      if (wr_do && aw_addr == A_CMD)
        cmd_q <= sgoc_cmd_t'(merge(32'h0, w_data, w_strb));
    end
  end

  // Read mux; unmapped words answer SLVERR with zero data
  always_comb
  begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    if (s_axi_araddr == A_CTRL)
      rd_mux = 32'(ctrl_local);
    else if (s_axi_araddr == A_VIN)
      rd_mux = 32'(vin);
    else if (s_axi_araddr == A_CMD)
      rd_mux = 32'h0;
    else if (s_axi_araddr == A_STS)
      rd_mux = 32'(sts);
    else if (s_axi_araddr == A_MASK)
      rd_mux = 32'(mask);
    else if (s_axi_araddr == A_POS)
      rd_mux = {8'h0, obj_fail, pos[7], pos[6], pos[5], pos[4], pos[3], pos[2], pos[1], pos[0]};
    else if (s_axi_araddr == A_OMAP)
      rd_mux = omap;
    else if (in_blk(s_axi_araddr, A_CFG))
      rd_mux = cfg[s_axi_araddr[4:2]];
    else if (in_blk(s_axi_araddr, A_TMR))
      rd_mux = tmr[s_axi_araddr[4:2]];
    else if (in_blk(s_axi_araddr, A_INH))
      rd_mux = 32'(inh[s_axi_araddr[4:2]]);
    else
      rd_ok = 1'b0;
    if (s_axi_araddr[1:0] != 2'h0)
      rd_ok = 1'b0;
  end

  // AXI read path plus read-to-clear of status; a new event in that cycle survives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
      sts           <= '0;
      irq           <= 1'b0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_ok ? rd_mux : 32'h0;
        s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready && s_axi_araddr == A_STS)
        sts <= {done_evt, undef_evt};
      else
        sts <= sts | {done_evt, undef_evt};
      irq <= |(sts & mask);
    end
  end

  AST_IRQ: assert property (1'b1 |=> irq == $past(|(sts & mask)))
    else $error("irq does not follow masked status");

  // Command outputs routed to physical outputs: 1..6 open, 7..12 close
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_out <= '0;
    else
      for (int k = 0; k < N_DO; k++)
      begin
        ctrl_out[k] <= 1'b0;
        for (int j = 0; j < N_CTL; j++)
          if (omap[k*OMAP_W +: OMAP_W] == OMAP_W'(j + 1))
            ctrl_out[k] <= open_cmd[j];
          else if (omap[k*OMAP_W +: OMAP_W] == OMAP_W'(j + 1 + N_CTL))
            ctrl_out[k] <= close_cmd[j];
      end
  end

  genvar i;
  generate
    for (i = 0; i < N_OBJ; i++)
    begin : g_obj
      logic [15:0] max_t;
      // Two indications decode to the four position codes
      assign pos[i] = {src_val(cfg[i].closed, pin_s2[7:0], vin, virt_out),
                       src_val(cfg[i].open, pin_s2[7:0], vin, virt_out)};
      assign max_t  = clamp(tmr[i][15:0]);
      if (i < N_CTL)
      begin : g_ctl
        sgoc_state_t st;
        logic        tgt_open;
        logic [1:0]  start_pos;
        logic [1:0]  tgt_pos;
        logic        inh_act;
        logic        hit;
        logic        req_open;
        logic        req_close;
        logic        has_ready;
        logic        rdy;
        logic        tmo;
        assign tgt_pos   = tgt_open ? POS_OPEN : POS_CLOSED;
        assign inh_act   = |(inh[i] & inh_vec);
        assign hit       = cmd_v && cmd_q.obj == 3'(i) && cmd_q.local_org == ctrl_local;
        // Pins on rising edges only, from the side that the local/remote state allows; ar_open/ar_close act on level in either state
        assign req_open  = (!ctrl_local && pin_s2[PIN_RO_LSB+i] && !pin_s3[PIN_RO_LSB+i])
                         || (ctrl_local && pin_s2[PIN_LO_LSB+i] && !pin_s3[PIN_LO_LSB+i])
                         || ar_open[i]
                         || (hit && !cfg[i].sel && cmd_q.act == ACT_DIR_OPEN);
        assign req_close = (!ctrl_local && pin_s2[PIN_RC_LSB+i] && !pin_s3[PIN_RC_LSB+i])
                         || (ctrl_local && pin_s2[PIN_LC_LSB+i] && !pin_s3[PIN_LC_LSB+i])
                         || ar_close[i]
                         || (hit && !cfg[i].sel && cmd_q.act == ACT_DIR_CLOSE);
        assign has_ready = cfg[i].ready.kind != SRC_NONE;
        assign rdy       = src_val(cfg[i].ready, pin_s2[7:0], vin, virt_out);
        assign tmo       = cnt[i] >= max_t;

        // Object control sequence, pulse outputs and failure flag
        always_ff @(posedge aclk)
        begin
          if (!aresetn)
          begin
            st            <= ST_IDLE;
            tgt_open      <= 1'b0;
            start_pos     <= POS_UNDEF0;
            cnt[i]        <= 16'h0;
            open_cmd[i]   <= 1'b0;
            close_cmd[i]  <= 1'b0;
            obj_fail[i]   <= 1'b0;
            undef_evt[i]  <= 1'b0;
            done_evt[i]   <= 1'b0;
          end
          else
          begin
            undef_evt[i] <= 1'b0;
            done_evt[i]  <= 1'b0;
            if (tick && cnt[i] != 16'hffff)
              cnt[i] <= cnt[i] + 16'h1;
            unique case (st)
              ST_IDLE:
                if (!inh_act && (req_open || req_close))
                begin
                  // Open wins a simultaneous request: the safe direction
                  st           <= ST_PULSE;
                  tgt_open     <= req_open;
                  open_cmd[i]  <= req_open;
                  close_cmd[i] <= !req_open;
                  start_pos    <= pos[i];
                  cnt[i]       <= 16'h0;
                end
                else if (hit && cfg[i].sel && (cmd_q.act == ACT_SEL_OPEN ||
                         cmd_q.act == ACT_SEL_CLOSE))
                begin
                  st       <= ST_SEL;
                  tgt_open <= cmd_q.act == ACT_SEL_OPEN;
                end
              ST_SEL:
                if (hit && cmd_q.act == ACT_CANCEL)
                  st <= ST_IDLE;
                else if (hit && cmd_q.act == ACT_EXEC)
                begin
                  st           <= inh_act ? ST_IDLE : ST_PULSE;
                  open_cmd[i]  <= !inh_act && tgt_open;
                  close_cmd[i] <= !inh_act && !tgt_open;
                  start_pos    <= pos[i];
                  cnt[i]       <= 16'h0;
                end
              ST_PULSE, ST_SETTLE:
                if (pos[i] == tgt_pos)
                begin
                  open_cmd[i]  <= 1'b0;
                  close_cmd[i] <= 1'b0;
                  obj_fail[i]  <= 1'b0;
                  done_evt[i]  <= !has_ready;
                  st           <= has_ready ? ST_READY : ST_IDLE;
                  cnt[i]       <= 16'h0;
                end
                else if (tmo)
                begin
                  open_cmd[i]  <= 1'b0;
                  close_cmd[i] <= 1'b0;
                  obj_fail[i]  <= 1'b1;
                  undef_evt[i] <= 1'b1;
                  st           <= ST_IDLE;
                end
                else if (pos[i] != start_pos)
                begin
                  open_cmd[i]  <= 1'b0;
                  close_cmd[i] <= 1'b0;
                  st           <= ST_SETTLE;
                end
              ST_READY:
                if (rdy)
                begin
                  done_evt[i] <= 1'b1;
                  st          <= ST_IDLE;
                end
                else if (cnt[i] >= clamp(tmr[i][31:16]))
                begin
                  obj_fail[i]  <= 1'b1;
                  undef_evt[i] <= 1'b1;
                  st           <= ST_IDLE;
                end
            endcase
          end
        end

        AST_EXCL: assert property (!(open_cmd[i] && close_cmd[i]))
          else $error("open and close pulsed together");
        AST_PULSE_MAX: assert property ((open_cmd[i] || close_cmd[i]) |-> cnt[i] <= max_t)
          else $error("command pulse outlived maximum length");
        AST_POS_END: assert property ((st == ST_PULSE && pos[i] != start_pos) |=>
                                      !open_cmd[i] && !close_cmd[i])
          else $error("pulse did not stop on position change");
        AST_TMO_FAIL: assert property (((st == ST_PULSE || st == ST_SETTLE) && tmo &&
                                        pos[i] != tgt_pos) |=> obj_fail[i] && undef_evt[i])
          else $error("timeout did not flag failure and event");
        AST_INHIBIT: assert property ((st == ST_IDLE && inh_act) |=>
                                      !open_cmd[i] && !close_cmd[i] && st != ST_PULSE)
          else $error("inhibited object was commanded");
        AST_LOCAL: assert property ((ctrl_local && st == ST_IDLE && !ar_open[i] && !ar_close[i]
                                     && !hit && !(pin_s2[PIN_LO_LSB+i] && !pin_s3[PIN_LO_LSB+i])
                                     && !(pin_s2[PIN_LC_LSB+i] && !pin_s3[PIN_LC_LSB+i]))
                                    |=> st == ST_IDLE)
          else $error("remote input acted in local state");
        AST_SEL_EXEC: assert property ((st == ST_SEL && !(hit && cmd_q.act == ACT_EXEC)) |=>
                                       st != ST_PULSE)
          else $error("selected object operated without execute");
        AST_READY: assert property (st == ST_READY |-> has_ready ##0 !open_cmd[i])
          else $error("ready supervision without ready source");
      end
      else
      begin : g_ro
        // Position-only object: supervise time spent undefined
        always_ff @(posedge aclk)
        begin
          if (!aresetn)
          begin
            cnt[i]       <= 16'h0;
            obj_fail[i]  <= 1'b0;
            undef_evt[i] <= 1'b0;
          end
          else
          begin
            undef_evt[i] <= 1'b0;
            if (pos[i] == POS_OPEN || pos[i] == POS_CLOSED)
            begin
              cnt[i]      <= 16'h0;
              obj_fail[i] <= 1'b0;
            end
            else if (cnt[i] >= max_t && !obj_fail[i])
            begin
              obj_fail[i]  <= 1'b1;
              undef_evt[i] <= 1'b1;
            end
            else if (tick && cnt[i] != 16'hffff)
              cnt[i] <= cnt[i] + 16'h1;
          end
        end

        AST_RO_FAIL: assert property ((pos[i] != POS_OPEN && pos[i] != POS_CLOSED &&
                                       cnt[i] >= max_t && !obj_fail[i]) |=> obj_fail[i] ##1 !undef_evt[i])
          else $error("read-only timeout did not flag failure");
      end
    end
  endgenerate
endmodule

//--- include/sgoc_pkg.sv
package sgoc_pkg;
  localparam int N_OBJ = 8;
  localparam int N_CTL = 6;
  localparam int N_DO  = 8;
  localparam int N_INH = 24;
  // Time base: all object timers count 10 ms ticks
  localparam int CLK_NS       = 8;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYC_DEF = TICK_MS * 1000000 / CLK_NS;
  localparam int TICK_W       = 21;
  localparam int TMR_MIN_MS   = 20;
  localparam int TMR_MAX_MS   = 600000;
  localparam int CTL_PULSE_MS = 60;
  localparam logic [15:0] TICKS_MIN = 16'((TMR_MIN_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [15:0] TICKS_MAX = 16'(TMR_MAX_MS / TICK_MS);
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_VIN  = 8'h04;
  localparam logic [7:0] A_CMD  = 8'h08;
  localparam logic [7:0] A_STS  = 8'h0c;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_POS  = 8'h14;
  localparam logic [7:0] A_OMAP = 8'h18;
  localparam logic [7:0] A_CFG  = 8'h20;
  localparam logic [7:0] A_TMR  = 8'h40;
  localparam logic [7:0] A_INH  = 8'h60;
  localparam logic [7:0] A_END  = 8'h80;
  localparam logic [31:0] TMR_RST = 32'h0064_0064;
  // Status layout and pin bundle layout
  localparam int STS_UNDEF_LSB = 0;
  localparam int STS_DONE_LSB  = 8;
  localparam int STS_W         = 14;
  localparam int POS_FAIL_LSB  = 16;
  localparam int PIN_RO_LSB    = 8;
  localparam int PIN_RC_LSB    = 14;
  localparam int PIN_LO_LSB    = 20;
  localparam int PIN_LC_LSB    = 26;
  localparam int OMAP_W        = 4;
  localparam logic [3:0] OMAP_NONE = 4'h0;
  localparam logic [1:0] POS_UNDEF0 = 2'h0;
  localparam logic [1:0] POS_OPEN   = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_DI   = 2'h1;
  localparam logic [1:0] SRC_VI   = 2'h2;
  localparam logic [1:0] SRC_VO   = 2'h3;
  localparam logic [2:0] ACT_SEL_OPEN  = 3'h0;
  localparam logic [2:0] ACT_SEL_CLOSE = 3'h1;
  localparam logic [2:0] ACT_EXEC      = 3'h2;
  localparam logic [2:0] ACT_CANCEL    = 3'h3;
  localparam logic [2:0] ACT_DIR_OPEN  = 3'h4;
  localparam logic [2:0] ACT_DIR_CLOSE = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] idx;
  } sgoc_src_t;
  typedef struct packed {
    logic [15:0] rsvd;
    logic        sel;
    sgoc_src_t   ready;
    sgoc_src_t   closed;
    sgoc_src_t   open;
  } sgoc_cfg_t;
  typedef struct packed {
    logic [24:0] rsvd;
    logic        local_org;
    logic [2:0]  act;
    logic [2:0]  obj;
  } sgoc_cmd_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_PULSE, ST_SETTLE, ST_READY} sgoc_state_t;
endpackage

//--- sim/sgoc_gear_model.sv
`timescale 1ns/1ns
module sgoc_gear_model
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  stuck,
  input  wire logic  open_cmd,
  input  wire logic  close_cmd,
  output logic [1:0] pos
);
  // Contacts move one cycle after a pulse; stuck jams the drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pos <= 2'h2;
    else if (!stuck && open_cmd)
      pos <= 2'h1; // {closed, open}
    else if (!stuck && close_cmd)
      pos <= 2'h2;
  end
endmodule

//--- sim/sgoc_top_tb_top.sv
`timescale 1ns/1ns
module sgoc_top_tb_top
  import sgoc_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0;
  logic        arv = 1'b0, rr = 1'b0, stuck = 1'b0, awr, wrd, bv, arr, rv, irq;
  logic [7:0]  awa = 8'h0, ara = 8'h0, ext = 8'h0, fail, cout;
  logic [31:0] wd = 32'h0, rdd, got;
  logic [1:0]  bres, rres, gresp, pos;
  logic [5:0]  aro = 6'h0, arc = 6'h0, rop = 6'h0, rcp = 6'h0, oc, cc;
  logic [3:0]  ws = 4'hf;
  int          errors = 0, cmp_count = 0, cyc = 0, k;
  sgoc_top #(.TICK_CYC(4)) sgoc_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bres),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rres), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .di_pin({6'h0, pos}), .rem_open_pin(rop), .rem_close_pin(rcp),
    .loc_open_pin(6'h0), .loc_close_pin(6'h0), .virt_out(8'h0), .ext_inhibit(ext),
    .ar_open(aro), .ar_close(arc), .open_cmd(oc), .close_cmd(cc), .obj_fail(fail),
    .ctrl_out(cout), .irq(irq));
  sgoc_gear_model sgoc_gear_model_inst (.aclk(aclk), .aresetn(aresetn), .stuck(stuck),
    .open_cmd(oc[0]), .close_cmd(cc[0]), .pos(pos));
  always #4 aclk = ~aclk;
  // Hang guard, far above the longest test
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      errors++;
      test_done();
    end
  end
  function automatic logic [31:0] inh_word(input int b);
    return 32'h1 << (16 + b);
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Each channel drops its valid at the edge it is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge aclk);
      awv <= awv & ~awr;
      wv <= wv & ~wrd;
    end
    while (bv !== 1'b1);
    gresp = bres;
    br <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge aclk);
      arv <= arv & ~arr;
    end
    while (rv !== 1'b1);
    got = rdd;
    gresp = rres;
    rr <= 1'b0;
  endtask
  // One-cycle auto-reclose request on object 1
  task automatic kick(input bit c);
    @(posedge aclk);
    if (c)
      arc <= 6'h1;
    else
      aro <= 6'h1;
    @(posedge aclk);
    aro <= 6'h0;
    arc <= 6'h0;
  endtask
  task automatic wfor(input int s);
    repeat (200)
    begin
      @(posedge aclk);
      if ((s == 0 && (oc[0] | cc[0])) || (s == 1 && fail[0]))
        break;
    end
  endtask
  initial
  begin
    void'($urandom(98));
    k = $urandom_range(7);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axr(A_TMR);
    chk("tmr_rst", got, TMR_RST);
    axr(8'h1c);
    chk("unmapped", gresp, RESP_SLVERR);
    axw(8'h1c, 32'h0);
    chk("wr_err", gresp, RESP_SLVERR);
    // Only byte 0 enabled: upper bytes keep their reset value
    ws <= 4'h1;
    axw(A_TMR, 32'hffff_ff05);
    ws <= 4'hf;
    axr(A_TMR);
    chk("wstrb", got, 32'h0064_0005);
    $display("test 1 done");
    // Object 1 opened through the gear model, routed to output 0
    axw(A_CFG, 32'h0000_0128);
    axw(A_TMR, 32'h0002_0004);
    axw(A_MASK, 32'h0000_0001);
    axw(A_OMAP, 32'h0000_0001);
    chk("wr_ok", gresp, RESP_OKAY);
    kick(0);
    wfor(0);
    chk("open_cmd", {oc[0], cc[0]}, 2'b10);
    @(posedge aclk);
    chk("ctrl_out", cout[0], 1'b1);
    repeat (20) @(posedge aclk);
    axr(A_POS);
    chk("pos", got[1:0], POS_OPEN);
    axr(A_STS);
    chk("done", got[8], 1'b1);
    $display("test 2 done");
    // Jammed drive: timeout marks failure and raises the event
    stuck <= 1'b1;
    kick(1);
    wfor(1);
    chk("fail", fail[0], 1'b1);
    chk("cmd_off", {oc[0], cc[0]}, 2'b00);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 1'b1);
    axr(A_STS);
    chk("undef", got[0], 1'b1);
    repeat (3) @(posedge aclk);
    chk("irq_clr", irq, 1'b0);
    $display("test 3 done");
    // Random inhibit line blocks, then a good close clears failure
    stuck <= 1'b0;
    axw(A_INH, inh_word(k));
    ext <= 8'h1 << k;
    kick(1);
    wfor(0);
    chk("inhibit", cc[0], 1'b0);
    ext <= 8'h0;
    kick(1);
    wfor(0);
    chk("close_cmd", cc[0], 1'b1);
    repeat (20) @(posedge aclk);
    chk("fail_clr", fail[0], 1'b0);
    $display("test 4 done");
    // Read-only object: undefined too long fails, defined clears
    axw(A_TMR + 8'h18, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    chk("ro_fail", fail[6], 1'b1);
    axw(A_CFG + 8'h18, 32'h0000_0128);
    repeat (2) @(posedge aclk);
    chk("ro_clr", fail[6], 1'b0);
    $display("test 5 done");
    // Remote pin edge, then local state, then select and execute
    rop <= 6'h1;
    wfor(0);
    chk("pin_open", oc[0], 1'b1);
    repeat (20) @(posedge aclk);
    chk("level_once", oc[0], 1'b0);
    rop <= 6'h0;
    axw(A_CTRL, 32'h1);
    rcp <= 6'h1;
    wfor(0);
    chk("remote_off", cc[0], 1'b0);
    rcp <= 6'h0;
    axw(A_CFG, 32'h0000_8128);
    axw(A_CMD, 32'h48);
    repeat (10) @(posedge aclk);
    chk("sel_wait", cc[0], 1'b0);
    axw(A_CMD, 32'h50);
    wfor(0);
    chk("exec", cc[0], 1'b1);
    $display("test 6 done");
    test_done();
  end
endmodule
